// [hdl/nvk_regs.v]
// Purpose: Key, control and status register bank of a memory programming interface.
// Assumes: APB slave, one wait state, 8-bit registers in the low byte of each word.
// Notes: The programming sequencer sits outside and drives the done/HV/violation inputs.
`timescale 1ns/1ps
`include "nvk_defines.vh"
module nvk_regs #(
  parameter [7:0] PROG_KEY_FIRST = `NVK_PKEY1,
  parameter [7:0] PROG_KEY_SECOND = `NVK_PKEY2,
  parameter [7:0] DATA_KEY_FIRST = `NVK_DKEY1,
  parameter [7:0] DATA_KEY_SECOND = `NVK_DKEY2
) (
  input wire ref_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire opDone,
  input wire opStart,
  input wire highVoltageOn,
  input wire protWrite,
  output reg memIrq,
  output reg eventIrq,
  output reg [7:0] ctrlOne,
  output reg [7:0] ctrlTwo,
  output reg programUnlocked,
  output reg dataUnlocked
);
  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire [2:0] regIdx = paddr[`NVK_ADDR_MSB:`NVK_ADDR_LSB];
  wire addrHigh = |paddr[31:`NVK_ADDR_MSB + 1];
  wire mapped = !addrHigh && (regIdx <= `NVK_IDX_ISTAT);
  // Access-phase acceptance; the answer comes one cycle after the first access cycle.
  wire accessNow = psel && penable && !pready;
  wire wrNow = accessNow && pwrite && mapped && pstrb[0];
  wire rdNow = accessNow && !pwrite && mapped;
  wire [7:0] wb = pwdata[7:0];

  reg [7:0] ctrlOne_q;
  reg [7:0] ctrlTwo_q;
  reg hvDone_q;
  reg dul_q;
  reg opd_q;
  reg pul_q;
  reg pwa_q;
  reg [`NVK_EV_W-1:0] evStat_q;
  reg [`NVK_EV_W-1:0] evMask_q;
  wire pulPulse;
  wire dulPulse;

  // ****************************************************************
  // Key checkers
  // ****************************************************************
  nvk_key_seq #(
    .KEY_FIRST(PROG_KEY_FIRST),
    .KEY_SECOND(PROG_KEY_SECOND),
    .ONE_SHOT(1)
  ) progKeys (
    .ref_clk(ref_clk),
    .reset(reset),
    .keyWr(wrNow && regIdx == `NVK_IDX_PKEY),
    .keyByte(wb),
    .unlockPulse(pulPulse)
  );

  // Wrong data keys may be retried without a reset.
  nvk_key_seq #(
    .KEY_FIRST(DATA_KEY_FIRST),
    .KEY_SECOND(DATA_KEY_SECOND),
    .ONE_SHOT(0)
  ) dataKeys (
    .ref_clk(ref_clk),
    .reset(reset),
    .keyWr(wrNow && regIdx == `NVK_IDX_DKEY),
    .keyByte(wb),
    .unlockPulse(dulPulse)
  );

  // ****************************************************************
  // Status image
  // ****************************************************************
  reg [7:0] statImage;
  always @* begin
    statImage = `NVK_ZERO_BYTE;
    statImage[`NVK_BIT_HVD] = hvDone_q;
    statImage[`NVK_BIT_DUL] = dul_q;
    statImage[`NVK_BIT_OPD] = opd_q;
    statImage[`NVK_BIT_PUL] = pul_q;
    statImage[`NVK_BIT_PWA] = pwa_q;
  end

  reg [7:0] rdByte;
  always @* begin
    case (regIdx)
      `NVK_IDX_CTRL1: rdByte = ctrlOne_q;
      `NVK_IDX_CTRL2: rdByte = ctrlTwo_q;
      `NVK_IDX_PKEY: rdByte = `NVK_ZERO_BYTE;
      `NVK_IDX_DKEY: rdByte = `NVK_ZERO_BYTE;
      `NVK_IDX_STAT: rdByte = statImage;
      `NVK_IDX_IMASK: rdByte = {{(8 - `NVK_EV_W){1'b0}}, evMask_q};
      `NVK_IDX_ISTAT: rdByte = {{(8 - `NVK_EV_W){1'b0}}, evStat_q};
      default: rdByte = `NVK_ZERO_BYTE;
    endcase
  end

  wire statRead = rdNow && regIdx == `NVK_IDX_STAT;
  wire statWrite = wrNow && regIdx == `NVK_IDX_STAT;
  wire opdSetNow = opDone && !opd_q;
  wire pwaSetNow = protWrite && !pwa_q;
  wire [`NVK_EV_W-1:0] evIn = {dulPulse, pulPulse, pwaSetNow, opdSetNow};

  // ****************************************************************
  // Register state
  // ****************************************************************
  always @(posedge ref_clk) begin
    if (reset) begin
      ctrlOne_q <= `NVK_CTRL1_RST;
      ctrlTwo_q <= `NVK_CTRL2_RST;
      hvDone_q <= 1'b1;
      dul_q <= 1'b0;
      opd_q <= 1'b0;
      pul_q <= 1'b0;
      pwa_q <= 1'b0;
      evStat_q <= {`NVK_EV_W{1'b0}};
      evMask_q <= {`NVK_EV_W{1'b0}};
    end else begin
      hvDone_q <= !highVoltageOn;
      if (wrNow && regIdx == `NVK_IDX_CTRL1) begin
        ctrlOne_q <= wb & `NVK_CTRL1_MASK;
      end
      if (wrNow && regIdx == `NVK_IDX_CTRL2) begin
        ctrlTwo_q <= wb & `NVK_CTRL2_MASK;
      end
      // Clear-by-zero flags: the hardware set wins over a same-cycle clear.
      if (dulPulse) begin
        dul_q <= 1'b1;
      end else if (statWrite && !wb[`NVK_BIT_DUL]) begin
        dul_q <= 1'b0;
      end
      if (pulPulse) begin
        pul_q <= 1'b1;
      end else if (statWrite && !wb[`NVK_BIT_PUL]) begin
        pul_q <= 1'b0;
      end
      if (opDone) begin
        opd_q <= 1'b1;
      end else if (statRead || opStart) begin
        opd_q <= 1'b0;
      end
      if (protWrite) begin
        pwa_q <= 1'b1;
      end else if (statRead) begin
        pwa_q <= 1'b0;
      end
      if (wrNow && regIdx == `NVK_IDX_IMASK) begin
        evMask_q <= wb[`NVK_EV_W-1:0];
      end
      if (wrNow && regIdx == `NVK_IDX_ISTAT) begin
        evStat_q <= (evStat_q & ~wb[`NVK_EV_W-1:0]) | evIn;
      end else begin
        evStat_q <= evStat_q | evIn;
      end
    end
  end

  // ****************************************************************
  // Bus answer and outputs
  // ****************************************************************
  always @(posedge ref_clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      memIrq <= 1'b0;
      eventIrq <= 1'b0;
      ctrlOne <= `NVK_CTRL1_RST;
      ctrlTwo <= `NVK_CTRL2_RST;
      programUnlocked <= 1'b0;
      dataUnlocked <= 1'b0;
    end else begin
      pready <= accessNow;
      pslverr <= accessNow && !mapped;
      if (rdNow) begin
        prdata <= {24'h000000, rdByte};
      end else begin
        prdata <= 32'h00000000;
      end
      // The request follows the flags with one register stage.
      memIrq <= ctrlOne_q[`NVK_BIT_IE] && (opd_q || pwa_q);
      eventIrq <= |(evStat_q & evMask_q);
      ctrlOne <= ctrlOne_q;
      ctrlTwo <= ctrlTwo_q;
      programUnlocked <= pul_q;
      dataUnlocked <= dul_q;
    end
  end
endmodule

// [include/nvk_defines.vh]
// Purpose: Register offsets, field positions, reset values and key constants.
// Assumes: APB byte addresses equal to four times the register index.
// Notes: Definitions only.
`ifndef NVK_DEFINES_VH
`define NVK_DEFINES_VH

`define NVK_IDX_CTRL1 3'h0
`define NVK_IDX_CTRL2 3'h1
`define NVK_IDX_PKEY 3'h2
`define NVK_IDX_DKEY 3'h3
`define NVK_IDX_STAT 3'h4
`define NVK_IDX_IMASK 3'h5
`define NVK_IDX_ISTAT 3'h6
`define NVK_ADDR_LSB 2
`define NVK_ADDR_MSB 4

`define NVK_CTRL1_RST 8'h00
`define NVK_CTRL1_MASK 8'h0F
`define NVK_CTRL2_RST 8'h00
`define NVK_CTRL2_MASK 8'hF1
`define NVK_STAT_RST 8'h40
`define NVK_ZERO_BYTE 8'h00

`define NVK_BIT_IE 1
`define NVK_BIT_HVD 6
`define NVK_BIT_DUL 3
`define NVK_BIT_OPD 2
`define NVK_BIT_PUL 1
`define NVK_BIT_PWA 0

`define NVK_EV_OPD 0
`define NVK_EV_PWA 1
`define NVK_EV_PUL 2
`define NVK_EV_DUL 3
`define NVK_EV_W 4

`define NVK_PKEY1 8'h56
`define NVK_PKEY2 8'hAE
`define NVK_DKEY1 8'hAE
`define NVK_DKEY2 8'h56

`endif

// [hdl/nvk_key_seq.v]
// Purpose: Two-byte unlock key sequence checker.
// Assumes: One write pulse per key byte.
// Notes: One-shot mode forbids further unlocking after any success or failure.
`timescale 1ns/1ps
module nvk_key_seq #(
  parameter [7:0] KEY_FIRST = 8'h56,
  parameter [7:0] KEY_SECOND = 8'hAE,
  parameter ONE_SHOT = 0
) (
  input wire ref_clk,
  input wire reset,
  input wire keyWr,
  input wire [7:0] keyByte,
  output reg unlockPulse
);
  reg gotFirst_q;
  reg dead_q;

  always @(posedge ref_clk) begin
    if (reset) begin
      gotFirst_q <= 1'b0;
      dead_q <= 1'b0;
      unlockPulse <= 1'b0;
    end else begin
      unlockPulse <= 1'b0;
      if (keyWr && !dead_q) begin
        if (!gotFirst_q) begin
          if (keyByte == KEY_FIRST) begin
            gotFirst_q <= 1'b1;
          end else if (ONE_SHOT != 0) begin
            dead_q <= 1'b1;
          end
        end else begin
          gotFirst_q <= 1'b0;
          // Both bytes must match in order before the unlock fires.
          if (keyByte == KEY_SECOND) begin
            unlockPulse <= 1'b1;
            if (ONE_SHOT != 0) begin
              dead_q <= 1'b1;
            end
          end else if (ONE_SHOT != 0) begin
            dead_q <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// [tb/nvk_regs_sva.sv]
// Purpose: Concurrent checks on the key and status register bank ports.
// Assumes: Zero-based byte addresses, one register per word, one clock.
// Notes: Bound to every nvk_regs instance.
`timescale 1ns/1ps
module nvk_regs_sva (
  input wire ref_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire opDone,
  input wire protWrite,
  input wire memIrq,
  input wire [7:0] ctrlOne,
  input wire programUnlocked,
  input wire dataUnlocked
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ***************************************************************
  // Program unlock history: once seen, it may never come back.
  // ***************************************************************
  logic pulSeen_q;
  always @(posedge ref_clk) begin
    if (reset) pulSeen_q <= 1'b0;
    else if (programUnlocked) pulSeen_q <= 1'b1;
  end
  sequence s_stWr;
    psel && penable && pready && pwrite && paddr == 32'h10 && pstrb[0];
  endsequence
  sequence s_rd(logic [31:0] a);
    pready && !pwrite && paddr == a;
  endsequence
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_dkey; s_rd(32'h0C) |-> prdata == 32'h0; endproperty
  a_dkey: assert property (p_dkey) else $error("key read not zero");
  property p_resv; s_rd(32'h10) |-> prdata[5:4] == 2'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_opIrq; opDone && ctrlOne[1] ##1 ctrlOne[1] |-> ##[0:2] memIrq; endproperty
  a_opIrq: assert property (p_opIrq) else $error("no irq on done");
  property p_pwIrq; protWrite && ctrlOne[1] ##1 ctrlOne[1] |-> ##[0:2] memIrq; endproperty
  a_pwIrq: assert property (p_pwIrq) else $error("no irq on violation");
  property p_gate; !ctrlOne[1] [*3] |-> !memIrq; endproperty
  a_gate: assert property (p_gate) else $error("irq while disabled");
  property p_keep; dataUnlocked && pwdata[3] ##0 s_stWr |=> ##1 dataUnlocked; endproperty
  a_keep: assert property (p_keep) else $error("write one cleared");
  property p_clr; dataUnlocked && !pwdata[3] ##0 s_stWr |=> ##1 !dataUnlocked; endproperty
  a_clr: assert property (p_clr) else $error("write zero kept");
  property p_once; pulSeen_q && !programUnlocked |=> !programUnlocked; endproperty
  a_once: assert property (p_once) else $error("second unlock");
  property p_err; psel && penable && !pready && paddr[4:2] == 3'h7 |=> pslverr; endproperty
  a_err: assert property (p_err) else $error("no slverr");
endmodule
bind nvk_regs nvk_regs_sva u_sva (.ref_clk(ref_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .opDone(opDone),
  .protWrite(protWrite), .memIrq(memIrq), .ctrlOne(ctrlOne),
  .programUnlocked(programUnlocked), .dataUnlocked(dataUnlocked));

// [tb/nvk_testbench.sv]
// Purpose: Directed bench for the key and status register bank.
// Assumes: One wait state per APB access, status at byte 0x10.
// Notes: Sequencer inputs are pulsed by the bench.
`timescale 1ns/1ps
module testbench;
  // ***************************************************************
  // Stimulus and checks
  // ***************************************************************
  logic ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd;
  logic [3:0] pstrb = 4'hF;
  logic opDone = 1'b0, opStart = 1'b0, highVoltageOn = 1'b0, protWrite = 1'b0, lastErr;
  wire [31:0] prdata;
  wire pready, pslverr, memIrq, eventIrq, programUnlocked, dataUnlocked;
  wire [7:0] ctrlOne, ctrlTwo;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  always #4 ref_clk = ~ref_clk;
  nvk_regs i_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .opDone(opDone), .opStart(opStart),
    .highVoltageOn(highVoltageOn), .protWrite(protWrite), .memIrq(memIrq),
    .eventIrq(eventIrq), .ctrlOne(ctrlOne), .ctrlTwo(ctrlTwo),
    .programUnlocked(programUnlocked), .dataUnlocked(dataUnlocked));
  task close_out;
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out;
    end
  end
  task cmp(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(nm, rd, e);
  endtask
  task rst;
    reset <= 1'b1;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
  endtask
  task pulse(input logic [2:0] k);
    @(posedge ref_clk);
    {opStart, protWrite, opDone} <= k;
    @(posedge ref_clk);
    {opStart, protWrite, opDone} <= 3'h0;
    repeat (2) @(posedge ref_clk);
  endtask
  task t_reset;
    rdc("status", 32'h10, 32'h40);
    rdc("dataKey", 32'h0C, 32'h0);
  endtask
  task t_data;
    apb(1'b1, 32'h0C, 32'h56);
    apb(1'b1, 32'h0C, 32'hAE);
    apb(1'b1, 32'h0C, 32'h56);
    rdc("dataUnl", 32'h10, 32'h48);
    cmp("dataUnlPin", dataUnlocked, 1'b1);
    rdc("dataKey", 32'h0C, 32'h0);
    apb(1'b1, 32'h10, 32'h0A);
    rdc("keepOne", 32'h10, 32'h48);
    apb(1'b1, 32'h10, 32'h02);
    rdc("clrZero", 32'h10, 32'h40);
  endtask
  task t_prog;
    apb(1'b1, 32'h08, 32'h11);
    apb(1'b1, 32'h08, 32'h56);
    apb(1'b1, 32'h08, 32'hAE);
    rdc("badKey", 32'h10, 32'h40);
    rst;
    apb(1'b1, 32'h08, 32'h56);
    apb(1'b1, 32'h08, 32'hAE);
    rdc("progUnl", 32'h10, 32'h42);
    cmp("progUnlPin", programUnlocked, 1'b1);
    apb(1'b1, 32'h10, 32'h08);
    rdc("progClr", 32'h10, 32'h40);
    apb(1'b1, 32'h08, 32'h56);
    apb(1'b1, 32'h08, 32'hAE);
    rdc("again", 32'h10, 32'h40);
  endtask
  task t_irq;
    apb(1'b1, 32'h00, 32'h02);
    pulse(3'h1);
    cmp("irqDone", memIrq, 1'b1);
    rdc("opDone", 32'h10, 32'h44);
    rdc("readClr", 32'h10, 32'h40);
    pulse(3'h2);
    // A status write with a zero in the violation bit must leave the read-cleared flag alone.
    apb(1'b1, 32'h10, 32'h0A);
    rdc("protWr", 32'h10, 32'h41);
    rdc("protClr", 32'h10, 32'h40);
    pulse(3'h1);
    pulse(3'h4);
    rdc("startClr", 32'h10, 32'h40);
    apb(1'b1, 32'h00, 32'h00);
    pulse(3'h2);
    cmp("irqOff", memIrq, 1'b0);
    rdc("protWr2", 32'h10, 32'h41);
  endtask
  task t_event;
    // Earlier scenarios left sticky events behind, so start from a clean word.
    apb(1'b1, 32'h18, 32'h0F);
    apb(1'b1, 32'h14, 32'h01);
    repeat (2) @(posedge ref_clk);
    cmp("evIdle", eventIrq, 1'b0);
    pulse(3'h1);
    cmp("evIrq", eventIrq, 1'b1);
    apb(1'b1, 32'h18, 32'h0F);
    repeat (2) @(posedge ref_clk);
    cmp("evClr", eventIrq, 1'b0);
  endtask
  task t_hv;
    highVoltageOn <= 1'b1;
    apb(1'b0, 32'h10, 32'h0);
    cmp("hvOn", rd[6], 1'b0);
    highVoltageOn <= 1'b0;
    apb(1'b0, 32'h10, 32'h0);
    cmp("high_voltage_done", rd[6], 1'b1);
    apb(1'b0, 32'h1C, 32'h0);
    cmp("unmapped", lastErr, 1'b1);
  endtask
  task t_ctrl;
    pstrb <= 4'h0;
    apb(1'b1, 32'h00, 32'h0D);
    pstrb <= 4'hF;
    cmp("strbErr", lastErr, 1'b0);
    rdc("strbOff", 32'h00, 32'h00);
    cmp("ctrlOnePin", ctrlOne, 8'h00);
    apb(1'b1, 32'h04, 32'h81);
    rdc("ctrlTwo", 32'h04, 32'h81);
    cmp("ctrlTwoPin", ctrlTwo, 8'h81);
  endtask
  initial begin
    rst;
    t_reset;
    t_data;
    t_prog;
    t_irq;
    t_event;
    t_hv;
    t_ctrl;
    close_out;
  end
endmodule
